// [core/itd_dchannel.sv]
// Terminal layer 1 D-channel access, activation primitives and INFO generation.
`timescale 1ns/10ps
module itd_dchannel
    import itd_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive-side conditions from the frame aligner.
    input  wire logic        line_connected,
    input  wire logic        frame_aligned,
    input  wire logic        a_bit_one,
    input  wire logic        echo_stb,
    input  wire logic        echo_bit,
    // Transmit timing.
    input  wire logic        d_slot_stb,
    input  wire logic        info1_bit_stb,
    // Layer 2 frame bits.
    input  wire logic        l2_pending,
    input  wire logic        l2_signalling,
    input  wire logic        l2_bit,
    input  wire logic        l2_last,
    output logic             l2_take,
    output logic             l2_done,
    output logic             l2_abort,
    // Line coder drive.
    output logic [1:0]       tx_info,
    output logic             tx_d_bit,
    output logic             tx_pos,
    output logic             tx_neg
);

    itd_act_t             act_state;
    itd_tx_t              tx_state;
    logic [ITD_CNT_W-1:0] echo_ones;
    logic [ITD_CNT_W-1:0] next_echo_ones;
    logic                 low1;
    logic                 low2;
    logic                 tx_class1;
    logic                 last_sent;
    logic                 info1_cap;
    logic                 act_req;
    logic                 deact_req;
    logic [ITD_EV_W-1:0]  events;
    logic [ITD_EV_W-1:0]  ev_set;
    logic [1:0]           err_code;
    logic                 err_open;
    logic                 conn_seen;
    logic                 aligned_seen;
    logic                 bus_ok;
    logic                 bus_wr;
    logic [ITD_CNT_W-1:0] thr;
    logic                 may_start;
    logic                 echo_check;
    logic                 mismatch;
    logic                 success;
    logic                 is_active;
    logic                 drop_to_deact;

    // Bus qualification: a transfer completes on the edge that sees pready.
    assign bus_ok = psel && penable && pready;
    assign bus_wr = bus_ok && pwrite;

    // Threshold for the waiting frame's class and the start condition.
    always_comb begin
        if (l2_signalling) begin
            thr = low1 ? ITD_X1_LOWER : ITD_X1_NORMAL;
        end else begin
            thr = low2 ? ITD_X2_LOWER : ITD_X2_NORMAL;
        end
    end
    assign is_active = (act_state == ITD_ST_ACTIVE);
    assign may_start = is_active && l2_pending && (echo_ones >= thr);

    // Echo comparison against the last bit put on the D-channel.
    assign echo_check = (tx_state == ITD_TX_SEND) && echo_stb;
    assign mismatch   = echo_check && (echo_bit != tx_d_bit);
    assign success    = echo_check && !mismatch && last_sent;

    // Leaving the active condition always ends a frame in progress.
    assign drop_to_deact = deact_req || !line_connected;

    // Consecutive ONE counter on the echo channel, saturating.
    always_comb begin
        next_echo_ones = echo_ones;
        if (!is_active) begin
            next_echo_ones = '0;
        end else if (echo_stb) begin
            if (!echo_bit) begin
                next_echo_ones = '0;
            end else if (echo_ones != ITD_CNT_MAX) begin
                next_echo_ones = echo_ones + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_ones <= '0;
        end else if (ce) begin
            echo_ones <= next_echo_ones;
        end
    end

    // Priority levels. A restore and a success in one cycle: success wins,
    // since the frame that just went out should give way to the others.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low1 <= 1'b0;
            low2 <= 1'b0;
        end else if (ce) begin
            if (echo_stb && next_echo_ones == ITD_X1_LOWER) begin
                low1 <= 1'b0;
            end
            if (echo_stb && next_echo_ones == ITD_X2_LOWER) begin
                low2 <= 1'b0;
            end
            if (success && tx_class1) begin
                low1 <= 1'b1;
            end
            if (success && !tx_class1) begin
                low2 <= 1'b1;
            end
        end
    end

    // D-channel transmit: monitor, send, and abandon on collision.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state  <= ITD_TX_MONITOR;
            tx_d_bit  <= 1'b1;
            tx_class1 <= 1'b0;
            last_sent <= 1'b0;
            l2_take   <= 1'b0;
            l2_done   <= 1'b0;
            l2_abort  <= 1'b0;
        end else if (ce) begin
            l2_take  <= 1'b0;
            l2_done  <= 1'b0;
            l2_abort <= 1'b0;
            case (tx_state)
                ITD_TX_MONITOR: begin
                    tx_d_bit  <= 1'b1;
                    last_sent <= 1'b0;
                    if (d_slot_stb && may_start) begin
                        tx_state  <= ITD_TX_SEND;
                        tx_d_bit  <= l2_bit;
                        tx_class1 <= l2_signalling;
                        last_sent <= l2_last;
                        l2_take   <= 1'b1;
                    end
                end
                ITD_TX_SEND: begin
                    if (!is_active || mismatch) begin
                        tx_state <= ITD_TX_MONITOR;
                        tx_d_bit <= 1'b1;
                        l2_abort <= 1'b1;
                    end else if (success) begin
                        tx_state <= ITD_TX_MONITOR;
                        tx_d_bit <= 1'b1;
                        l2_done  <= 1'b1;
                    end else if (d_slot_stb && !last_sent) begin
                        tx_d_bit  <= l2_bit;
                        last_sent <= l2_last;
                        l2_take   <= 1'b1;
                    end
                end
                default: begin
                    tx_state <= ITD_TX_MONITOR;
                    tx_d_bit <= 1'b1;
                end
            endcase
        end
    end

    // Activation state and the primitives it raises.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_state <= ITD_ST_DEACT;
        end else if (ce) begin
            case (act_state)
                ITD_ST_DEACT: begin
                    if (line_connected && frame_aligned) begin
                        act_state <= ITD_ST_SYNC;
                    end else if (line_connected && act_req && info1_cap) begin
                        act_state <= ITD_ST_AWAIT;
                    end
                end
                ITD_ST_AWAIT: begin
                    if (drop_to_deact) begin
                        act_state <= ITD_ST_DEACT;
                    end else if (frame_aligned) begin
                        act_state <= ITD_ST_SYNC;
                    end
                end
                ITD_ST_SYNC: begin
                    if (drop_to_deact || !frame_aligned) begin
                        act_state <= ITD_ST_DEACT;
                    end else if (a_bit_one) begin
                        act_state <= ITD_ST_ACTIVE;
                    end
                end
                ITD_ST_ACTIVE: begin
                    if (drop_to_deact || !frame_aligned) begin
                        act_state <= ITD_ST_DEACT;
                    end
                end
                default: act_state <= ITD_ST_DEACT;
            endcase
        end
    end

    // Signal code to the line coder: INFO 1 while awaiting, INFO 3 once aligned.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_info <= ITD_INFO0;
        end else if (ce) begin
            case (act_state)
                ITD_ST_AWAIT:  tx_info <= ITD_INFO1;
                ITD_ST_SYNC:   tx_info <= ITD_INFO3;
                ITD_ST_ACTIVE: tx_info <= ITD_INFO3;
                default:       tx_info <= ITD_INFO0;
            endcase
        end
    end

    // Event sources for the event register.
    always_comb begin
        ev_set = '0;
        if (act_state != ITD_ST_ACTIVE && act_state != ITD_ST_DEACT
            && !drop_to_deact && frame_aligned && a_bit_one
            && act_state == ITD_ST_SYNC) begin
            ev_set[ITD_EV_PH_AI]  = 1'b1;
            ev_set[ITD_EV_MPH_AI] = 1'b1;
        end
        if (act_state != ITD_ST_DEACT && (drop_to_deact || (!frame_aligned
            && act_state != ITD_ST_AWAIT))) begin
            ev_set[ITD_EV_PH_DI]  = 1'b1;
            ev_set[ITD_EV_MPH_DI] = 1'b1;
        end
        if (aligned_seen != frame_aligned && (err_open || is_active)) begin
            ev_set[ITD_EV_MPH_EI] = 1'b1;
        end
        ev_set[ITD_EV_II_CONN]  = line_connected && !conn_seen;
        ev_set[ITD_EV_II_DISC]  = !line_connected && conn_seen;
        ev_set[ITD_EV_COLLIDE]  = (tx_state == ITD_TX_SEND) && mismatch;
        ev_set[ITD_EV_DONE]     = success;
    end

    // Edge history for connection and alignment, and the error code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conn_seen    <= 1'b0;
            aligned_seen <= 1'b0;
            err_code     <= ITD_ERR_NONE;
            err_open     <= 1'b0;
        end else if (ce) begin
            conn_seen    <= line_connected;
            aligned_seen <= frame_aligned;
            if (is_active && aligned_seen && !frame_aligned) begin
                err_code <= ITD_ERR_FRAMING;
                err_open <= 1'b1;
            end else if (err_open && !aligned_seen && frame_aligned) begin
                err_code <= ITD_ERR_RECOVER;
                err_open <= 1'b0;
            end
        end
    end

    // Control register; request bits are one-cycle commands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_req   <= 1'b0;
            deact_req <= 1'b0;
            info1_cap <= ITD_INFO1_CAP_RST;
        end else if (ce) begin
            act_req   <= 1'b0;
            deact_req <= 1'b0;
            if (bus_wr && paddr == ITD_OFF_CTRL) begin
                act_req   <= pwdata[ITD_CTRL_ACT_REQ];
                deact_req <= pwdata[ITD_CTRL_DEACT_REQ];
                info1_cap <= pwdata[ITD_CTRL_INFO1_CAP];
            end
        end
    end

    // Sticky events: a new event in the clearing cycle survives the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= '0;
        end else if (ce) begin
            if (bus_wr && paddr == ITD_OFF_EVENT) begin
                events <= (events & ~pwdata[ITD_EV_W-1:0]) | ev_set;
            end else begin
                events <= events | ev_set;
            end
        end
    end

    // APB answer: one wait state, registered data and error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            prdata  <= '0;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                case (paddr)
                    ITD_OFF_CTRL:   prdata <= {29'h0, info1_cap, 2'h0};
                    ITD_OFF_STATUS: prdata <= {16'h0, low2, low1, tx_state,
                                               echo_ones, act_state, 4'h0};
                    ITD_OFF_EVENT:  prdata <= {23'h0, events};
                    ITD_OFF_ERROR:  prdata <= {29'h0, err_open, err_code};
                    default:        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // INFO 1 pattern runs only while awaiting a signal.
    itd_info1_gen u_info1 (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .enable    (act_state == ITD_ST_AWAIT),
        .bit_stb   (info1_bit_stb),
        .pulse_pos (tx_pos),
        .pulse_neg (tx_neg)
    );

endmodule : itd_dchannel

// [core/itd_info1_gen.sv]
// INFO 1 pattern generator: positive ZERO, negative ZERO, six ONEs, repeated.
`timescale 1ns/10ps
module itd_info1_gen
    import itd_pkg::*;
(
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    // Control.
    input  wire logic enable,
    input  wire logic bit_stb,
    // Ternary line drive, ONE is no pulse.
    output logic      pulse_pos,
    output logic      pulse_neg
);

    logic [2:0] slot;

    // Slot counter walks the eight-bit pattern one slot per bit strobe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot <= 3'h0;
        end else if (ce) begin
            if (!enable) begin
                slot <= 3'h0;
            end else if (bit_stb) begin
                slot <= (slot == ITD_I1_LAST) ? 3'h0 : slot + 3'h1;
            end
        end
    end

    // Pulses are registered so the line coder sees clean levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_pos <= 1'b0;
            pulse_neg <= 1'b0;
        end else if (ce) begin
            pulse_pos <= enable && (slot == ITD_I1_POS_SLOT);
            pulse_neg <= enable && (slot == ITD_I1_NEG_SLOT);
        end
    end

endmodule : itd_info1_gen

// [core/itd_pkg.sv]
// Constants and types shared by the terminal D-channel access block.
package itd_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] ITD_OFF_CTRL   = 8'h00;
    localparam logic [7:0] ITD_OFF_STATUS = 8'h04;
    localparam logic [7:0] ITD_OFF_EVENT  = 8'h08;
    localparam logic [7:0] ITD_OFF_ERROR  = 8'h0c;

    // Control register fields.
    localparam int ITD_CTRL_ACT_REQ   = 0;
    localparam int ITD_CTRL_DEACT_REQ = 1;
    localparam int ITD_CTRL_INFO1_CAP = 2;
    localparam logic ITD_INFO1_CAP_RST = 1'b1;

    // Event register fields, write one to clear.
    localparam int ITD_EV_PH_AI    = 0;
    localparam int ITD_EV_MPH_AI   = 1;
    localparam int ITD_EV_PH_DI    = 2;
    localparam int ITD_EV_MPH_DI   = 3;
    localparam int ITD_EV_MPH_EI   = 4;
    localparam int ITD_EV_II_CONN  = 5;
    localparam int ITD_EV_II_DISC  = 6;
    localparam int ITD_EV_COLLIDE  = 7;
    localparam int ITD_EV_DONE     = 8;
    localparam int ITD_EV_W        = 9;

    // Echo ones count and access thresholds.
    localparam int         ITD_CNT_W       = 4;
    localparam logic [3:0] ITD_CNT_MAX     = 4'hb;
    localparam logic [3:0] ITD_X1_NORMAL   = 4'h8;
    localparam logic [3:0] ITD_X1_LOWER    = 4'h9;
    localparam logic [3:0] ITD_X2_NORMAL   = 4'ha;
    localparam logic [3:0] ITD_X2_LOWER    = 4'hb;

    // Transmitted signal code handed to the line coder.
    localparam logic [1:0] ITD_INFO0 = 2'h0;
    localparam logic [1:0] ITD_INFO1 = 2'h1;
    localparam logic [1:0] ITD_INFO3 = 2'h3;

    // Error indication codes.
    localparam logic [1:0] ITD_ERR_NONE    = 2'h0;
    localparam logic [1:0] ITD_ERR_FRAMING = 2'h1;
    localparam logic [1:0] ITD_ERR_RECOVER = 2'h2;

    // INFO 1 pattern: length and the two slots carrying pulses.
    localparam logic [2:0] ITD_I1_POS_SLOT = 3'h0;
    localparam logic [2:0] ITD_I1_NEG_SLOT = 3'h1;
    localparam logic [2:0] ITD_I1_LAST     = 3'h7;

    // Activation state.
    typedef enum logic [3:0] {
        ITD_ST_DEACT  = 4'b0001,
        ITD_ST_AWAIT  = 4'b0010,
        ITD_ST_SYNC   = 4'b0100,
        ITD_ST_ACTIVE = 4'b1000
    } itd_act_t;

    // D-channel transmit state.
    typedef enum logic [1:0] {
        ITD_TX_MONITOR = 2'b01,
        ITD_TX_SEND    = 2'b10
    } itd_tx_t;

endpackage : itd_pkg

// [verification/itd_dchannel_chk.sv]
// Port assertions for the terminal D-channel access block.
`timescale 1ns/10ps
module itd_dchannel_chk
    import itd_pkg::*;
(
    // Clock and reset.
    input wire logic       pclk,
    input wire logic       presetn,
    // Inputs of interest.
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       echo_stb,
    input wire logic       echo_bit,
    input wire logic       d_slot_stb,
    input wire logic       l2_pending,
    input wire logic       l2_bit,
    // Outputs under watch.
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       l2_take,
    input wire logic       l2_done,
    input wire logic       l2_abort,
    input wire logic [1:0] tx_info,
    input wire logic       tx_d_bit,
    input wire logic       tx_pos,
    input wire logic       tx_neg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic sending;
    // Frame in flight, from l2_take to l2_done or l2_abort; no port holds it as a level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sending <= 1'b0;
        else if (l2_done || l2_abort)
            sending <= 1'b0;
        else if (l2_take)
            sending <= 1'b1;
    end
    sequence s_pos_end;
        (tx_pos && tx_info == ITD_INFO1) ##1 (!tx_pos && tx_info == ITD_INFO1);
    endsequence
    sequence s_setup_access;
        (psel && !penable) ##1 (psel && penable);
    endsequence
    property p_wait;  s_setup_access |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_slverr;
        pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ITD_OFF_ERROR);
    endproperty
    property p_take;  l2_take |-> $past(d_slot_stb) && $past(l2_pending); endproperty
    property p_bit;   l2_take |-> tx_d_bit == $past(l2_bit); endproperty
    property p_clash; sending && echo_stb && echo_bit != tx_d_bit |=> l2_abort; endproperty
    property p_match; sending && echo_stb && echo_bit == tx_d_bit |=> !l2_abort; endproperty
    property p_idle;  d_slot_stb && !sending |=> l2_take || tx_d_bit; endproperty
    property p_done;  l2_done |-> sending && $past(echo_stb); endproperty
    property p_info1; s_pos_end |-> tx_neg; endproperty
    a_wait:   assert property (p_wait) else $error("no ready after one wait state");
    a_pulse:  assert property (p_pulse) else $error("ready longer than one cycle");
    a_slverr: assert property (p_slverr) else $error("wrong slave error");
    a_take:   assert property (p_take) else $error("bit taken outside slot");
    a_bit:    assert property (p_bit) else $error("sent bit differs");
    a_clash:  assert property (p_clash) else $error("no abort on clash");
    a_match:  assert property (p_match) else $error("abort on match");
    a_idle:   assert property (p_idle) else $error("idle slot not ONE");
    a_done:   assert property (p_done) else $error("done without echo");
    a_info1:  assert property (p_info1) else $error("no negative after positive");
endmodule : itd_dchannel_chk

bind itd_dchannel itd_dchannel_chk itd_dchannel_chk_i (.*, .tx_neg(tx_neg));

// [verification/itd_dchannel_tb_top.sv]
// Self-checking bench for the terminal D-channel access block.
`timescale 1ns/10ps
module itd_dchannel_tb_top import itd_pkg::*;;
    localparam int INFO1_DIV = 1042;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fbad;
    logic line_connected, frame_aligned, a_bit_one, echo_stb, echo_bit, d_slot_stb;
    logic info1_bit_stb, l2_pending, l2_signalling, l2_bit, l2_last, l2_take, l2_done;
    logic l2_abort, tx_d_bit, tx_pos, tx_neg, clash, lv1, lv2, ce;
    logic [1:0]  tx_info, stage;
    logic [2:0]  fidx;
    logic [3:0]  ones;
    logic [7:0]  paddr, fbits;
    logic [31:0] pwdata, prdata;
    logic [32:0] msk;
    logic [32:0] rd_q[$], rm_q[$];
    logic [1:0]  fr_q[$];
    int compares, fail_count, div, np, nn;

    itd_dchannel itd_dchannel_i (.*);
    itd_nt_model itd_nt_model_i (.*);

    always #2.5 pclk = ~pclk;

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Bus cycle; an idle cycle follows so no signal is set twice at one edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        rd_q.push_back(e);
        rm_q.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        apb(1'b0, a, 32'h0, e, m);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask : wr

    // Random payload; bit six is a ONE so a forced clash shows on it.
    task automatic frame(input logic cls, input logic bad);
        fbits = {2'b01, 5'($urandom), 1'b0};
        fbad = bad;
        fidx = 3'h0;
        fr_q.push_back({!bad, bad});
        l2_signalling <= cls;
        l2_bit <= 1'b0;
        l2_last <= 1'b0;
        l2_pending <= 1'b1;
        @(posedge pclk iff (l2_done === 1'b1 || l2_abort === 1'b1));
        @(posedge pclk);
        rd(ITD_OFF_STATUS, {17'h0, lv2, lv1, 14'h0}, 33'hc000);
    endtask : frame

    // INFO 1 bit clock near 192 kbit/s.
    always @(posedge pclk) begin
        div <= (div == INFO1_DIV - 1) ? 0 : div + 1;
        info1_bit_stb <= div == 0;
    end

    // Reference echo count, priority levels, frame source and result checks.
    always @(posedge pclk) begin
        if (echo_stb === 1'b1) begin
            ones <= !echo_bit ? 4'h0 : (ones == ITD_CNT_MAX ? ones : ones + 4'h1);
            if (echo_bit && ones == ITD_X1_NORMAL) lv1 <= 1'b0;
            if (echo_bit && ones == ITD_X2_NORMAL) lv2 <= 1'b0;
        end
        if (l2_take === 1'b1) begin
            if (fidx == 3'h0) begin
                chk(33'(ones >= (l2_signalling ? (lv1 ? ITD_X1_LOWER : ITD_X1_NORMAL)
                    : (lv2 ? ITD_X2_LOWER : ITD_X2_NORMAL))), 33'h1);
                clash <= fbad;
            end
            fidx <= fidx + 3'h1;
            l2_bit <= fbits[3'h6 - fidx];
            l2_last <= fidx == 3'h6;
            if (l2_last) l2_pending <= 1'b0;
        end
        if (l2_done === 1'b1 || l2_abort === 1'b1) begin
            chk(33'({l2_done, l2_abort}), 33'(fr_q.pop_front()));
            if (l2_done && l2_signalling) lv1 <= 1'b1;
            if (l2_done && !l2_signalling) lv2 <= 1'b1;
            clash <= 1'b0;
            l2_pending <= 1'b0;
        end
        if (pready === 1'b1) begin
            msk = rm_q.pop_front();
            chk({pslverr, prdata} & msk, rd_q.pop_front() & msk);
        end
    end

    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        results();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, clash, lv1, lv2} = '0;
        {l2_pending, l2_signalling, l2_bit, l2_last, fbad} = '0;
        {paddr, pwdata, stage, fidx, ones, fbits, div} = '0;
        ce = 1'b1;
        void'($urandom(32'h2e1e84a7));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ITD_OFF_STATUS, 33'h1010, 33'h0_ffff_ffff);
        rd(ITD_OFF_ERROR, 33'h0, 33'h1_ffff_ffff);
        rd(8'h10, 33'h1_0000_0000, 33'h1_0000_0000);
        stage <= 2'h1;
        wr(ITD_OFF_CTRL, 32'h1);
        rd(ITD_OFF_STATUS, 33'h10, 33'hf0);
        wr(ITD_OFF_CTRL, 32'h5);
        rd(ITD_OFF_STATUS, 33'h20, 33'hf0);
        rd(ITD_OFF_CTRL, 33'h4, 33'h1_ffff_ffff);
        chk(33'(tx_info), 33'(ITD_INFO1));
        {np, nn, msk} = '0;
        repeat (16) begin
            @(posedge pclk iff info1_bit_stb);
            repeat (2) @(posedge pclk);
            if (msk[0]) chk(33'(tx_neg), 33'h1);
            msk[0] = tx_pos;
            np += int'(tx_pos);
            nn += int'(tx_neg);
        end
        chk(33'(np * 16 + nn), 33'h22);
        stage <= 2'h2;
        repeat (4) @(posedge pclk);
        rd(ITD_OFF_STATUS, 33'h40, 33'hf0);
        chk(33'(tx_info), 33'(ITD_INFO3));
        stage <= 2'h3;
        repeat (8) @(posedge pclk);
        rd(ITD_OFF_STATUS, 33'h80, 33'hf0);
        rd(ITD_OFF_EVENT, 33'h23, 33'h1ff);
        wr(ITD_OFF_EVENT, 32'h1ff);
        rd(ITD_OFF_EVENT, 33'h0, 33'h1ff);
        chk(33'(tx_d_bit), 33'h1);
        for (int k = 0; k < 4; k++) frame(k < 2, k == 3);
        stage <= 2'h1;
        repeat (4) @(posedge pclk);
        rd(ITD_OFF_ERROR, 33'h5, 33'h7);
        rd(ITD_OFF_EVENT, 33'h19c, 33'h19c);
        stage <= 2'h3;
        repeat (8) @(posedge pclk);
        rd(ITD_OFF_ERROR, 33'h2, 33'h7);
        wr(ITD_OFF_EVENT, 32'h1ff);
        wr(ITD_OFF_CTRL, 32'h6);
        rd(ITD_OFF_EVENT, 33'hc, 33'hc);
        // With the enable low the disconnect must not move the state yet.
        ce <= 1'b0;
        stage <= 2'h0;
        repeat (4) @(posedge pclk);
        chk(33'(tx_info), 33'(ITD_INFO3)); // Frozen while the enable is low.
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(ITD_OFF_EVENT, 33'h40, 33'h40);
        chk(33'(rd_q.size() + fr_q.size()), 33'h0);
        results();
    end
endmodule : itd_dchannel_tb_top

// [verification/itd_nt_model.sv]
// Network termination model: line states, D slots and echo reflection.
`timescale 1ns/10ps
module itd_nt_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Scene: 0 silent, 1 signal, 2 INFO 2, 3 INFO 4; clash forces echo ZERO.
    input  wire logic [1:0] stage,
    input  wire logic       clash,
    input  wire logic       tx_d_bit,
    // Receive conditions seen by the terminal.
    output logic            line_connected,
    output logic            frame_aligned,
    output logic            a_bit_one,
    output logic            d_slot_stb,
    output logic            echo_stb,
    output logic            echo_bit
);
    logic [2:0] phase;
    // A is ZERO in INFO 2 and ONE in INFO 4.
    assign line_connected = stage != 2'h0;
    assign frame_aligned  = stage[1];
    assign a_bit_one      = stage == 2'h3;
    // Slot every eight cycles, echo four later; the unused echo wire toggles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 3'h0;
            d_slot_stb <= 1'b0;
            echo_stb <= 1'b0;
            echo_bit <= 1'b1;
        end else begin
            phase <= phase + 3'h1;
            d_slot_stb <= frame_aligned && phase == 3'h7;
            echo_stb <= frame_aligned && phase == 3'h3;
            echo_bit <= phase == 3'h3 ? tx_d_bit && a_bit_one && !clash : !echo_bit;
        end
    end
endmodule : itd_nt_model
